// File: core/wake_rx_pkg.sv
// constants and types shared by the carrier wake-up receiver core
package wake_rx_pkg;
   localparam int unsigned QUAL_PERIODS = 192;
   localparam int unsigned SETTLE_PERIODS = 512;
   localparam int unsigned MIN_PREAMBLE_PERIODS = 704;
   localparam int unsigned GAIN_DOWN_PERIODS = 2;
   localparam int unsigned GAIN_UP_PERIODS = 8;
   localparam int unsigned FILTER_TAPS = 4;
   localparam int unsigned FILTER_MIN_DELAY = 3;
   localparam int unsigned FILTER_MAX_DELAY = 6;
   localparam int unsigned GAIN_STEPS = 16;
   localparam logic [3:0] GAIN_MAX = 4'hF;
   typedef enum logic [1:0] {ST_LISTEN, ST_SETTLE, ST_ARMED, ST_AWAKE} mode_t;
endpackage

// File: core/carrier_smoother.sv
// full-window hysteresis smoothing filter on the demodulated per-period carrier flag
`timescale 1ns/10ps
module carrier_smoother #(
   parameter int unsigned TAPS = 4
)(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic period_tick,
   input wire logic raw_carrier,
   output logic carrier_f
);
   typedef struct packed
   {
      logic [TAPS-1:0] hist;
      logic carrier;
   } sm_state_t;
   sm_state_t s_q, s_d;
   initial
   begin
      if (TAPS < 2 || TAPS > 5)
      begin
         $error("carrier_smoother: TAPS out of range");
      end
   end
   // hysteresis: full window flips the output, so single dropouts and glitches vanish
   always_comb
   begin
      s_d = s_q;
      // the reset pin empties the window too, so no old carrier survives standby
      if (clear)
      begin
         s_d = '0;
      end
      else if (period_tick)
      begin
         s_d.hist = {s_q.hist[TAPS-2:0], raw_carrier};
         if (&s_d.hist)
         begin
            s_d.carrier = 1'b1;
         end
         else if (~|s_d.hist)
         begin
            s_d.carrier = 1'b0;
         end
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
   assign carrier_f = s_q.carrier;
endmodule

// File: core/wake_rx_core.sv
// digital core of the carrier wake-up receiver: qualify, gain loop, wake and data
`timescale 1ns/10ps
module wake_rx_core #(
   parameter int unsigned QUAL = wake_rx_pkg::QUAL_PERIODS,
   parameter int unsigned SETTLE = wake_rx_pkg::SETTLE_PERIODS
)(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic reset_in,
   input wire logic carrier_clk,
   input wire logic env_above_half,
   input wire logic amp_above_target,
   input wire logic factory_pin_a,
   input wire logic factory_pin_b,
   output logic wake_out_n,
   output logic data_out,
   output logic [3:0] gain_step,
   output logic gain_loop_on
);
   initial
   begin
      if (QUAL < 2 || QUAL > 1023 || SETTLE < 1 || SETTLE > 1023)
      begin
         $error("wake_rx_core: count parameters out of range");
      end
   end

   // ==========================================================
   // state
   typedef struct packed
   {
      logic [1:0] rst_s;
      logic [1:0] clk_s;
      logic [1:0] half_s;
      logic [1:0] tgt_s;
      logic clk_prev;
      logic tick;
      logic raw;
      logic tgt;
      wake_rx_pkg::mode_t mode;
      logic [9:0] qual_cnt;
      logic [9:0] settle_cnt;
      logic [3:0] gain;
      logic [1:0] hi_cnt;
      logic [3:0] lo_cnt;
      logic loop_on;
      logic wake_n;
      logic data;
   } core_state_t;
   core_state_t s_q, s_d;
   logic carrier_f;

   // ==========================================================
   // smoothing filter
   carrier_smoother #(
      .TAPS(wake_rx_pkg::FILTER_TAPS)
   ) u_smooth (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clear(s_q.rst_s[1]),
      .period_tick(s_q.tick),
      .raw_carrier(s_q.raw),
      .carrier_f(carrier_f)
   );

   // ==========================================================
   // next state
   always_comb
   begin
      s_d = s_q;
      // pins from outside the clock domain pass two flops first
      s_d.rst_s = {s_q.rst_s[0], reset_in};
      s_d.clk_s = {s_q.clk_s[0], carrier_clk};
      s_d.half_s = {s_q.half_s[0], env_above_half};
      s_d.tgt_s = {s_q.tgt_s[0], amp_above_target};
      s_d.clk_prev = s_q.clk_s[1];
      s_d.tick = s_q.clk_s[1] & ~s_q.clk_prev;
      // comparator polarity: above half level is logic 1, carrier; below is a gap
      s_d.raw = s_q.half_s[1];
      s_d.tgt = s_q.tgt_s[1];
      if (s_q.rst_s[1])
      begin
         // held reset pin keeps the whole core in power-down / listen
         s_d.mode = wake_rx_pkg::ST_LISTEN;
         s_d.qual_cnt = '0;
         s_d.settle_cnt = '0;
         s_d.gain = wake_rx_pkg::GAIN_MAX;
         s_d.hi_cnt = '0;
         s_d.lo_cnt = '0;
         s_d.loop_on = 1'b0;
         s_d.wake_n = 1'b1;
         s_d.data = 1'b1;
      end
      else if (s_q.tick)
      begin
         case (s_q.mode)
            wake_rx_pkg::ST_LISTEN:
            begin
               s_d.gain = wake_rx_pkg::GAIN_MAX;
               s_d.loop_on = 1'b0;
               // only filtered gaps restart the count; raw dropouts are invisible
               if (!carrier_f)
               begin
                  s_d.qual_cnt = '0;
               end
               else if (s_q.qual_cnt == 10'(QUAL - 1))
               begin
                  s_d.mode = wake_rx_pkg::ST_SETTLE;
                  s_d.loop_on = 1'b1;
                  s_d.qual_cnt = '0;
               end
               else
               begin
                  s_d.qual_cnt = s_q.qual_cnt + 10'h001;
               end
            end
            wake_rx_pkg::ST_SETTLE:
            begin
               // gap before settle window ends still counts as the start gap
               if (!carrier_f)
               begin
                  s_d.mode = wake_rx_pkg::ST_AWAKE;
                  s_d.wake_n = 1'b0;
               end
               else if (s_q.settle_cnt == 10'(SETTLE - 1))
               begin
                  s_d.mode = wake_rx_pkg::ST_ARMED;
               end
               else
               begin
                  s_d.settle_cnt = s_q.settle_cnt + 10'h001;
               end
            end
            wake_rx_pkg::ST_ARMED:
            begin
               if (!carrier_f)
               begin
                  s_d.mode = wake_rx_pkg::ST_AWAKE;
                  s_d.wake_n = 1'b0;
               end
            end
            wake_rx_pkg::ST_AWAKE:
            begin
               // no exit: only the reset pin leaves this state
               s_d.wake_n = 1'b0;
            end
            default:
            begin
               s_d.mode = wake_rx_pkg::ST_LISTEN;
            end
         endcase
         // stepwise gain loop, active outside listen
         if (s_q.loop_on)
         begin
            if (s_q.tgt)
            begin
               s_d.lo_cnt = '0;
               if (s_q.hi_cnt == 2'(wake_rx_pkg::GAIN_DOWN_PERIODS - 1))
               begin
                  s_d.hi_cnt = '0;
                  if (s_q.gain != 4'h0)
                  begin
                     s_d.gain = s_q.gain - 4'h1;
                  end
               end
               else
               begin
                  s_d.hi_cnt = s_q.hi_cnt + 2'h1;
               end
            end
            else
            begin
               s_d.hi_cnt = '0;
               if (s_q.lo_cnt == 4'(wake_rx_pkg::GAIN_UP_PERIODS - 1))
               begin
                  s_d.lo_cnt = '0;
                  if (s_q.gain != wake_rx_pkg::GAIN_MAX)
                  begin
                     s_d.gain = s_q.gain + 4'h1;
                  end
               end
               else
               begin
                  s_d.lo_cnt = s_q.lo_cnt + 4'h1;
               end
            end
         end
      end
      // data output: high in standby, follows filtered carrier once awake
      if (s_d.mode == wake_rx_pkg::ST_AWAKE)
      begin
         s_d.data = carrier_f;
      end
      else
      begin
         s_d.data = 1'b1;
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q.rst_s <= '0;
         s_q.clk_s <= '0;
         s_q.half_s <= '0;
         s_q.tgt_s <= '0;
         s_q.clk_prev <= 1'b0;
         s_q.tick <= 1'b0;
         s_q.raw <= 1'b0;
         s_q.tgt <= 1'b0;
         s_q.mode <= wake_rx_pkg::ST_LISTEN;
         s_q.qual_cnt <= '0;
         s_q.settle_cnt <= '0;
         s_q.gain <= wake_rx_pkg::GAIN_MAX;
         s_q.hi_cnt <= '0;
         s_q.lo_cnt <= '0;
         s_q.loop_on <= 1'b0;
         s_q.wake_n <= 1'b1;
         s_q.data <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // outputs straight from flops
   assign wake_out_n = s_q.wake_n;
   assign data_out = s_q.data;
   assign gain_step = s_q.gain;
   assign gain_loop_on = s_q.loop_on;
endmodule

// File: verification/carrier_tx.sv
// remote transmitter model: carrier period clock, envelope level and amplitude level
`timescale 1ns/10ps
module carrier_tx (
   output logic carrier_clk,
   output logic env_above_half,
   output logic amp_above_target
);
   // ====
   // burst
   initial
   begin
      carrier_clk = 1'b0;
      env_above_half = 1'b0;
      amp_above_target = 1'b0;
   end
   // n periods of carrier (c=1) or gap (c=0); levels settle well before each edge
   task automatic send(input int n, input logic c, input logic amp);
      env_above_half = c;
      amp_above_target = amp;
      repeat (n)
      begin
         #150 carrier_clk = 1'b1;
         #250 carrier_clk = 1'b0;
         #100;
      end
   endtask
endmodule

// File: verification/wake_rx_core_sva.sv
// assertion checker on the ports of the carrier wake-up receiver core
`timescale 1ns/10ps
module wake_rx_core_sva #(
   parameter int unsigned QUAL = 8,
   parameter int unsigned SETTLE = 64
)(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic reset_in,
   input wire logic wake_out_n,
   input wire logic data_out,
   input wire logic [3:0] gain_step,
   input wire logic gain_loop_on
);
   // ====
   // output relations
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   held_standby_a: assert property (reset_in && $past(reset_in, 4) |-> gain_step == 4'hF &&
      !gain_loop_on && wake_out_n && data_out) else $error("standby outputs wrong");
   reset_clear_a: assert property ($rose(reset_in) |-> ##[1:4] (wake_out_n && data_out &&
      gain_step == 4'hF && !gain_loop_on)) else $error("reset pin did not clear");
   wake_hold_a: assert property (!wake_out_n && !reset_in |=> !wake_out_n)
      else $error("wake released without reset");
   data_off_a: assert property (wake_out_n |-> data_out)
      else $error("data active in standby");
   wake_gap_a: assert property ($fell(wake_out_n) |-> ##[0:1] !data_out)
      else $error("wake without gap on data");
   gain_one_step_a: assert property (gain_loop_on && $past(gain_loop_on) && $changed(gain_step)
      |-> gain_step == $past(gain_step) + 4'h1 || gain_step == $past(gain_step) - 4'h1)
      else $error("gain moved more than one step");
   gain_idle_a: assert property (!gain_loop_on && !$past(gain_loop_on) |-> $stable(gain_step))
      else $error("gain moved with loop off");
   loop_before_wake_a: assert property ($rose(gain_loop_on) |-> wake_out_n && data_out)
      else $error("gain loop started after wake");
   data_smooth_a: assert property ($changed(data_out) && !wake_out_n && !$past(wake_out_n)
      |=> ($stable(data_out) || wake_out_n)[*8])
      else $error("data changed faster than filter");
endmodule
bind wake_rx_core wake_rx_core_sva #(.QUAL(QUAL), .SETTLE(SETTLE)) chk_u (.sys_clk(sys_clk),
   .rst_n(rst_n), .reset_in(reset_in), .wake_out_n(wake_out_n), .data_out(data_out),
   .gain_step(gain_step), .gain_loop_on(gain_loop_on));

// File: verification/tb_wake_rx_core.sv
// self-checking bench for the carrier wake-up receiver core
`timescale 1ns/10ps
module tb_wake_rx_core;
   // short counts keep the run brief
   localparam int unsigned QUAL = 8;
   localparam int unsigned SETTLE = 64;
   logic sys_clk, rst_n, reset_in, carrier_clk, env_above_half, amp_above_target;
   logic wake_out_n, data_out, gain_loop_on, b, p;
   logic [3:0] gain_step, g;
   int miscompares = 0;
   int n_tests = 0;
   int cycles = 0;
   // ====
   // structure
   wake_rx_core #(.QUAL(QUAL), .SETTLE(SETTLE)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
      .reset_in(reset_in), .carrier_clk(carrier_clk), .env_above_half(env_above_half),
      .amp_above_target(amp_above_target), .factory_pin_a(1'b0), .factory_pin_b(1'b0),
      .wake_out_n(wake_out_n), .data_out(data_out), .gain_step(gain_step),
      .gain_loop_on(gain_loop_on));
   carrier_tx tx_u (.carrier_clk(carrier_clk), .env_above_half(env_above_half),
      .amp_above_target(amp_above_target));
   // clock and a hang guard well above the expected few thousand cycles
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         miscompares = miscompares + 1;
         end_sim();
      end
   end
   // ====
   // checking
   task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // standby picture: full gain, loop idle, both outputs high
   task automatic standby();
      check("gain", gain_step, 4'hF);
      check("loop", gain_loop_on, 1'b0);
      check("wake", wake_out_n, 1'b1);
      check("data", data_out, 1'b1);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ====
   // sequence
   initial
   begin
      rst_n = 1'b0;
      reset_in = 1'b0;
      p = 1'b0;
      void'($urandom(32'hF4766182));
      repeat (3) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      standby();
      // a gap that survives smoothing restarts qualification
      tx_u.send(7, 1'b1, 1'b0);
      tx_u.send(6, 1'b0, 1'b0);
      standby();
      // a single dropout is smoothed away, so the count completes
      tx_u.send(5, 1'b1, 1'b0);
      tx_u.send(1, 1'b0, 1'b0);
      tx_u.send(12, 1'b1, 1'b0);
      check("loop", gain_loop_on, 1'b1);
      check("wake", wake_out_n, 1'b1);
      // loud input lowers gain, eight quiet periods raise it one step
      tx_u.send(4, 1'b1, 1'b1);
      g = gain_step;
      check("down", 4'(g < 4'hF), 4'h1);
      tx_u.send(9, 1'b1, 1'b0);
      check("up", gain_step, g + 4'h1);
      tx_u.send(50, 1'b1, 1'b0);
      // start gap wakes the controller and opens the data path
      tx_u.send(6, 1'b0, 1'b0);
      check("wake", wake_out_n, 1'b0);
      check("data", data_out, 1'b0);
      // random line code passes through after the smoothing delay
      repeat (12)
      begin
         b = 1'($urandom);
         tx_u.send(2, b, 1'($urandom));
         check("early", data_out, p);
         tx_u.send(5, b, 1'b0);
         check("data", data_out, b);
         p = b;
      end
      check("wake", wake_out_n, 1'b0);
      // reset pin held high keeps standby even under carrier
      @(posedge sys_clk);
      #1 reset_in = 1'b1;
      tx_u.send(20, 1'b1, 1'b0);
      standby();
      @(posedge sys_clk);
      #1 reset_in = 1'b0;
      // fresh preamble, then power-on reset in mid settle
      tx_u.send(16, 1'b1, 1'b0);
      check("loop", gain_loop_on, 1'b1);
      @(posedge sys_clk);
      #1 rst_n = 1'b0;
      @(posedge sys_clk);
      #1 rst_n = 1'b1;
      standby();
      end_sim();
   end
endmodule
